// ===== pkg/dmc_pkg.sv
// constants for the mode register five configuration block
//--------------------------------------------------------------
//--------------------------------------------------------------
package dmc_pkg;
   localparam int CFG_W = 18;
   localparam logic [2:0] SEL_THIS_REG = 3'h5;
   localparam logic [CFG_W-1:0] CFG_RESET = 18'h00000;
   // bits 17, 16:14 and 13 are never stored
   localparam logic [CFG_W-1:0] CFG_WR_MASK = 18'h01FE7;
   localparam int BIT_RD_INV = 12;
   localparam int BIT_WR_INV = 11;
   localparam int BIT_MASK = 10;
   localparam int BIT_PERSIST = 9;
   localparam int PARK_HI = 8;
   localparam int PARK_LO = 6;
   localparam int BIT_BUF_OFF = 5;
   localparam int BIT_PAR_ERR = 4;
   localparam int BIT_CRC_ERR = 3;
   localparam int LAT_HI = 2;
   localparam int LAT_LO = 0;
   localparam logic [2:0] LAT_OFF = 3'h0;
   localparam logic [2:0] LAT_4CK = 3'h1;
   localparam logic [2:0] LAT_5CK = 3'h2;
   localparam logic [2:0] LAT_6CK = 3'h3;
endpackage : dmc_pkg

// ===== rtl/dmc_pulse_xfer.sv
// single-cycle event crossing by toggle
module dmc_pulse_xfer (
   input wire logic src_clk_i,
   input wire logic src_rst_i,
   input wire logic src_pulse_i,
   input wire logic dst_clk_i,
   input wire logic dst_rst_i,
   output logic dst_pulse_o
);
   logic tgl_q;
   logic tgl_s;
   logic tgl_seen_q;

   always_ff @(posedge src_clk_i) begin
      if (src_rst_i) begin
         tgl_q <= 1'b0;
      end else if (src_pulse_i) begin
         tgl_q <= ~tgl_q;
      end
   end

   dmc_sync #(.W(1), .RST_VAL(1'b0)) u_sync (
      .clk_i(dst_clk_i),
      .rst_i(dst_rst_i),
      .d_i(tgl_q),
      .q_o(tgl_s)
   );

   always_ff @(posedge dst_clk_i) begin
      if (dst_rst_i) begin
         tgl_seen_q <= 1'b0;
         dst_pulse_o <= 1'b0;
      end else begin
         tgl_seen_q <= tgl_s;
         dst_pulse_o <= tgl_s ^ tgl_seen_q;
      end
   end
endmodule // dmc_pulse_xfer

// ===== rtl/dmc_sync.sv
// two flip-flop level synchroniser
module dmc_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= RST_VAL;
         q_o <= RST_VAL;
      end else begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end
endmodule // dmc_sync

// ===== rtl/dmc_top.sv
// mode register five: command decode on the link clock, config and status
module dmc_top
   import dmc_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic clk_link_i,
   input wire logic reset_n_i,
   input wire logic cs_n_i,
   input wire logic act_n_i,
   input wire logic ras_n_i,
   input wire logic cas_n_i,
   input wire logic we_n_i,
   input wire logic [1:0] bank_group_pins_i,
   input wire logic [1:0] bank_i,
   input wire logic a17_i,
   input wire logic [13:0] addr_i,
   input wire logic cmd_par_err_i,
   input wire logic max_power_save_i,
   input wire logic crc_err_i,
   input wire logic mpr_read_i,
   input wire logic power_down_i,
   output logic cmd_exec_o,
   output logic [CFG_W-1:0] cfg_o,
   output logic rd_inv_apply_o,
   output logic nominal_term_en_o,
   output logic par_check_en_o
);
   //--------------------------------------------------------------
   // link domain reset and level crossings
   //--------------------------------------------------------------
   logic rst_l_s;
   logic pin_rst_n_s;
   logic link_rst;
   logic mpsm_l;
   logic chk_l;
   logic pin_rst_sys_s;
   logic sys_rst;

   dmc_sync #(.W(1), .RST_VAL(1'b1)) u_rst_link (
      .clk_i(clk_link_i),
      .rst_i(1'b0),
      .d_i(rst_i),
      .q_o(rst_l_s)
   );

   dmc_sync #(.W(1), .RST_VAL(1'b0)) u_pin_rst (
      .clk_i(clk_link_i),
      .rst_i(1'b0),
      .d_i(reset_n_i),
      .q_o(pin_rst_n_s)
   );

   assign link_rst = rst_l_s | ~pin_rst_n_s;

   dmc_sync #(.W(2), .RST_VAL(2'h0)) u_to_link (
      .clk_i(clk_link_i),
      .rst_i(link_rst),
      .d_i({max_power_save_i, par_check_en_o}),
      .q_o({mpsm_l, chk_l})
   );

   // the reset pin also clears the register held on the system clock
   dmc_sync #(.W(1), .RST_VAL(1'b1)) u_pin_to_sys (
      .clk_i(clk_sys_i),
      .rst_i(rst_i),
      .d_i(~pin_rst_n_s),
      .q_o(pin_rst_sys_s)
   );

   assign sys_rst = rst_i | pin_rst_sys_s;

   //--------------------------------------------------------------
   // command decode on the link clock
   //--------------------------------------------------------------
   logic cmd_sel;
   logic is_mrs;
   logic par_bad;
   logic cmd_ok;
   logic wr_hit;
   logic [CFG_W-1:0] wr_word_l_q;
   logic wr_evt_l_q;
   logic par_evt_l_q;

   assign cmd_sel = ~cs_n_i;
   assign is_mrs = cmd_sel & act_n_i & ~ras_n_i & ~cas_n_i & ~we_n_i;
   assign par_bad = chk_l & cmd_par_err_i;
   assign cmd_ok = cmd_sel & ~mpsm_l & ~par_bad;
   assign wr_hit = cmd_ok & is_mrs & ~bank_group_pins_i[1]
                   & ({bank_group_pins_i[0], bank_i} == SEL_THIS_REG);

   always_ff @(posedge clk_link_i) begin
      if (link_rst) begin
         cmd_exec_o <= 1'b0;
      end else begin
         cmd_exec_o <= cmd_ok;
      end
   end

   // word held until the next write; writes must be spaced out
   always_ff @(posedge clk_link_i) begin
      if (link_rst) begin
         wr_word_l_q <= CFG_RESET;
         wr_evt_l_q <= 1'b0;
      end else begin
         wr_evt_l_q <= wr_hit;
         if (wr_hit) begin
            wr_word_l_q <= {a17_i, 3'h0, addr_i};
         end
      end
   end

   // a command lost in power save mode raises nothing
   always_ff @(posedge clk_link_i) begin
      if (link_rst) begin
         par_evt_l_q <= 1'b0;
      end else begin
         par_evt_l_q <= cmd_sel & ~mpsm_l & par_bad;
      end
   end

   //--------------------------------------------------------------
   // events into the system clock
   //--------------------------------------------------------------
   logic wr_s;
   logic par_evt_s;

   dmc_pulse_xfer u_wr_xfer (
      .src_clk_i(clk_link_i),
      .src_rst_i(link_rst),
      .src_pulse_i(wr_evt_l_q),
      .dst_clk_i(clk_sys_i),
      .dst_rst_i(sys_rst),
      .dst_pulse_o(wr_s)
   );

   dmc_pulse_xfer u_par_xfer (
      .src_clk_i(clk_link_i),
      .src_rst_i(link_rst),
      .src_pulse_i(par_evt_l_q),
      .dst_clk_i(clk_sys_i),
      .dst_rst_i(sys_rst),
      .dst_pulse_o(par_evt_s)
   );

   //--------------------------------------------------------------
   // configuration register and sticky status
   //--------------------------------------------------------------
   logic [CFG_W-1:0] wr_word;
   logic [2:0] lat;

   assign wr_word = wr_word_l_q;
   assign lat = cfg_o[LAT_HI:LAT_LO];

   // one process for the whole word keeps a single driver per bit
   // reserved bits never stored, read zero
   // fields loaded on write
   // set beats a clearing write in the same cycle
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst) begin
         cfg_o <= CFG_RESET;
      end else begin
         if (wr_s) begin
            cfg_o[CFG_W-1:BIT_BUF_OFF] <= wr_word[CFG_W-1:BIT_BUF_OFF]
                                          & CFG_WR_MASK[CFG_W-1:BIT_BUF_OFF];
            cfg_o[LAT_HI:LAT_LO] <= wr_word[LAT_HI:LAT_LO];
         end
         cfg_o[BIT_PAR_ERR] <= par_evt_s
                               | (cfg_o[BIT_PAR_ERR] & ~(wr_s & ~wr_word[BIT_PAR_ERR]));
         cfg_o[BIT_CRC_ERR] <= crc_err_i
                               | (cfg_o[BIT_CRC_ERR] & ~(wr_s & ~wr_word[BIT_CRC_ERR]));
      end
   end

   //--------------------------------------------------------------
   // derived controls
   //--------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst) begin
         par_check_en_o <= 1'b0;
      end else begin
         par_check_en_o <= (lat == LAT_4CK || lat == LAT_5CK || lat == LAT_6CK)
                           && (cfg_o[BIT_PERSIST] || !cfg_o[BIT_PAR_ERR]);
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst) begin
         rd_inv_apply_o <= 1'b0;
      end else begin
         rd_inv_apply_o <= cfg_o[BIT_RD_INV] & ~mpr_read_i;
      end
   end

   // parked termination stays with the field regardless
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst) begin
         nominal_term_en_o <= 1'b1;
      end else begin
         nominal_term_en_o <= ~(power_down_i & cfg_o[BIT_BUF_OFF]);
      end
   end

   //--------------------------------------------------------------
   // checks
   //--------------------------------------------------------------
   par_set_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst)
      par_evt_s |=> cfg_o[BIT_PAR_ERR])
      else $error("parity event did not set status");

   crc_set_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst)
      crc_err_i |=> cfg_o[BIT_CRC_ERR])
      else $error("checksum error did not set status");

   crc_hold_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst)
      (cfg_o[BIT_CRC_ERR] && !wr_s) |=> cfg_o[BIT_CRC_ERR])
      else $error("checksum status dropped without write");

   crc_clear_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst)
      (wr_s && !wr_word[BIT_CRC_ERR] && !crc_err_i) |=> !cfg_o[BIT_CRC_ERR])
      else $error("zero write did not clear checksum status");

   par_hold_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst)
      (cfg_o[BIT_PAR_ERR] && !wr_s) |=> cfg_o[BIT_PAR_ERR])
      else $error("parity status dropped without write");

   par_clear_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst)
      (wr_s && !wr_word[BIT_PAR_ERR] && !par_evt_s) |=> !cfg_o[BIT_PAR_ERR])
      else $error("zero write did not clear parity status");

   chk_stop_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst)
      (cfg_o[BIT_PAR_ERR] && !cfg_o[BIT_PERSIST]) |=> !par_check_en_o)
      else $error("checking went on after error in normal mode");

   chk_keep_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst)
      (cfg_o[BIT_PERSIST] && lat != LAT_OFF && !lat[2]) |=> par_check_en_o)
      else $error("persistent mode stopped checking");

   lat_rsvd_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst)
      (lat[2] || lat == LAT_OFF) |=> !par_check_en_o)
      else $error("reserved or off latency enabled checking");

   rd_inv_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst)
      mpr_read_i |=> !rd_inv_apply_o)
      else $error("read inversion during readout");

   field_load_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst)
      wr_s |=> cfg_o[BIT_RD_INV:BIT_BUF_OFF] == $past(wr_word[BIT_RD_INV:BIT_BUF_OFF]))
      else $error("write did not load fields");

   mpsm_gate_a: assert property (@(posedge clk_link_i) disable iff (link_rst)
      (mpsm_l && cmd_sel) |=> !cmd_exec_o && !wr_evt_l_q)
      else $error("command executed in power save mode");

   par_block_a: assert property (@(posedge clk_link_i) disable iff (link_rst)
      (chk_l && cmd_par_err_i) |=> !cmd_exec_o)
      else $error("command with parity error executed");

   rd_inv_on_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst)
      (cfg_o[BIT_RD_INV] && !mpr_read_i) |=> rd_inv_apply_o)
      else $error("read inversion not applied");

   term_off_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst)
      (power_down_i && cfg_o[BIT_BUF_OFF]) |=> !nominal_term_en_o)
      else $error("nominal termination kept with buffer off");

   term_on_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst)
      !cfg_o[BIT_BUF_OFF] |=> nominal_term_en_o)
      else $error("nominal termination dropped with buffer on");

   lat_load_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst)
      wr_s |=> cfg_o[LAT_HI:LAT_LO] == $past(wr_word[LAT_HI:LAT_LO]))
      else $error("write did not load latency");

   field_rsvd_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst)
      wr_s |=> cfg_o[CFG_W-1:BIT_RD_INV+1] == '0)
      else $error("reserved bits stored");

   //--------------------------------------------------------------
   // checks on the link clock
   //--------------------------------------------------------------
   mrs_latch_a: assert property (@(posedge clk_link_i) disable iff (link_rst)
      wr_hit |=> wr_evt_l_q && (wr_word_l_q == {$past(a17_i), 3'h0, $past(addr_i)}))
      else $error("register write not latched from pins");

   mrs_only_a: assert property (@(posedge clk_link_i) disable iff (link_rst)
      (cmd_ok && !is_mrs) |=> cmd_exec_o && !wr_evt_l_q)
      else $error("other command taken as register write");

   par_event_a: assert property (@(posedge clk_link_i) disable iff (link_rst)
      (cmd_sel && !mpsm_l && par_bad) |=> par_evt_l_q && !wr_evt_l_q)
      else $error("parity failure not reported");

   mpsm_quiet_a: assert property (@(posedge clk_link_i) disable iff (link_rst)
      (mpsm_l && cmd_sel) |=> !par_evt_l_q)
      else $error("power save command raised parity event");
endmodule // dmc_top

// ===== verif/dmc_ctrl_model.sv
// controller model: issues mode writes and other commands on the link clock
module dmc_ctrl_model (
   input wire logic clk_link_i,
   input wire logic cmd_exec_i,
   output logic cs_n_o,
   output logic act_n_o,
   output logic ras_n_o,
   output logic cas_n_o,
   output logic we_n_o,
   output logic [21:17] hi_o,
   output logic [13:0] addr_o,
   output logic par_err_o
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      cs_n_o = 1'b1;
      {act_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hF;
      hi_o = 5'h00;
      addr_o = 14'h0000;
      par_err_o = 1'b0;
   end
   // ---------------------------------------
   // one command, then pins released
   // ---------------------------------------
   task automatic send(input logic [21:0] w, input logic bad, input logic [3:0] strb,
      output logic ex);
      @(posedge clk_link_i);
      #1;
      cs_n_o = 1'b0;
      // strobes from strb (act_n_o high, others low for a write), word on pins
      {act_n_o, ras_n_o, cas_n_o, we_n_o} = strb;
      // reserved bits always sent as zero
      hi_o = w[21:17] & 5'h0E;
      addr_o = w[13:0] & 14'h1FFF;
      par_err_o = bad;
      @(posedge clk_link_i);
      #1;
      ex = cmd_exec_i;
      cs_n_o = 1'b1;
      // released pins flip, so a held value cannot pass for a command
      {act_n_o, ras_n_o, cas_n_o, we_n_o} = 4'h7;
      hi_o = ~hi_o;
      addr_o = ~addr_o;
      par_err_o = ~bad;
   endtask
endmodule // dmc_ctrl_model

// ===== verif/dram_mode5_config_tb.sv
// self-checking bench for the mode register five block
module dram_mode5_config_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import dmc_pkg::*;
   // ---------------------------------------
   // clocks, pins and instances
   // ---------------------------------------
   localparam logic [21:0] SEL5 = 22'h140000;
   logic clk_sys_i = 1'b0, clk_link_i = 1'b0, rst_i = 1'b1, reset_n_i = 1'b1;
   logic max_power_save_i = 1'b0, crc_err_i = 1'b0, mpr_read_i = 1'b0, power_down_i = 1'b0;
   logic cs_n_i, act_n_i, ras_n_i, cas_n_i, we_n_i, cmd_par_err_i;
   logic [21:17] hi;
   logic [13:0] addr_i;
   logic cmd_exec_o, rd_inv_apply_o, nominal_term_en_o, par_check_en_o;
   logic [CFG_W-1:0] cfg_o;
   int n_errors = 0;
   int check_count = 0;
   always #20 clk_sys_i = ~clk_sys_i;
   always #3 clk_link_i = ~clk_link_i;
   dmc_ctrl_model mdl (.clk_link_i, .cmd_exec_i(cmd_exec_o), .cs_n_o(cs_n_i),
      .act_n_o(act_n_i), .ras_n_o(ras_n_i), .cas_n_o(cas_n_i), .we_n_o(we_n_i),
      .hi_o(hi), .addr_o(addr_i), .par_err_o(cmd_par_err_i));
   dmc_top dut (.clk_sys_i, .rst_i, .clk_link_i, .reset_n_i, .cs_n_i, .act_n_i, .ras_n_i,
      .cas_n_i, .we_n_i, .bank_group_pins_i(hi[21:20]), .bank_i(hi[19:18]), .a17_i(hi[17]),
      .addr_i, .cmd_par_err_i, .max_power_save_i, .crc_err_i, .mpr_read_i, .power_down_i,
      .cmd_exec_o, .cfg_o, .rd_inv_apply_o, .nominal_term_en_o, .par_check_en_o);
   // ---------------------------------------
   // helpers
   // ---------------------------------------
   task step(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask
   task chk(input string what, input logic [17:0] exp, input logic [17:0] got);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h got %h", what, exp, got);
      end
   endtask
   // spacing of 10 cycles keeps writes apart and covers the crossing
   task wr(input logic [21:0] w, input logic bad, input logic exp_ex);
      logic ex;
      mdl.send(w, bad, 4'h8, ex);
      chk("cmd_exec_o", 18'(exp_ex), 18'(ex));
      step(10);
   endtask
   task finish_test;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // ---------------------------------------
   // scenarios
   // ---------------------------------------
   task t_fields;
      static logic [12:0] tb_w [8] = '{13'h1000, 13'h0841, 13'h0482, 13'h02C3,
         13'h0124, 13'h015D, 13'h0186, 13'h01C7};
      logic ex;
      chk("cfg_o", 18'h00000, cfg_o);
      chk("nominal_term_en_o", 18'(1), 18'(nominal_term_en_o));
      // no gear-down here, 5-clock latency allowed
      foreach (tb_w[i]) begin
         wr(SEL5 | 22'(tb_w[i]), 1'b0, 1'b1);
         chk("cfg_o", {5'h00, tb_w[i][12:5], 2'h0, tb_w[i][2:0]}, cfg_o);
         chk("par_check_en_o", 18'(tb_w[i][2:0] inside {3'h1, 3'h2, 3'h3}),
            18'(par_check_en_o));
         chk("rd_inv_apply_o", 18'(tb_w[i][12]), 18'(rd_inv_apply_o));
      end
      wr(22'h101FE7, 1'b0, 1'b1);
      chk("cfg_o", 18'h001C7, cfg_o);
      mdl.send(SEL5 | 22'h01000, 1'b0, 4'h9, ex);
      chk("cmd_exec_o", 18'(1), 18'(ex));
      step(10);
      chk("cfg_o", 18'h001C7, cfg_o);
      $display("end of field test");
   endtask
   task t_pins;
      wr(SEL5 | 22'h010E0, 1'b0, 1'b1);
      mpr_read_i = 1'b1;
      power_down_i = 1'b1;
      step(2);
      chk("rd_inv_apply_o", 18'(0), 18'(rd_inv_apply_o));
      chk("nominal_term_en_o", 18'(0), 18'(nominal_term_en_o));
      chk("cfg_o", 18'h010E0, cfg_o);
      mpr_read_i = 1'b0;
      wr(SEL5 | 22'h010C0, 1'b0, 1'b1);
      chk("nominal_term_en_o", 18'(1), 18'(nominal_term_en_o));
      chk("rd_inv_apply_o", 18'(1), 18'(rd_inv_apply_o));
      power_down_i = 1'b0;
      $display("end of pin test");
   endtask
   task t_status;
      crc_err_i = 1'b1;
      step(1);
      crc_err_i = 1'b0;
      chk("cfg_o crc", 18'(1), 18'(cfg_o[3]));
      wr(SEL5 | 22'h00008, 1'b0, 1'b1);
      chk("cfg_o crc", 18'(1), 18'(cfg_o[3]));
      wr(SEL5, 1'b0, 1'b1);
      chk("cfg_o crc", 18'(0), 18'(cfg_o[3]));
      wr(SEL5 | 22'h00001, 1'b0, 1'b1);
      wr(SEL5 | 22'h00001, 1'b1, 1'b0);
      chk("cfg_o", 18'h00011, cfg_o);
      chk("par_check_en_o", 18'(0), 18'(par_check_en_o));
      wr(SEL5 | 22'h00201, 1'b1, 1'b1);
      chk("cfg_o", 18'h00201, cfg_o);
      wr(SEL5 | 22'h00201, 1'b1, 1'b0);
      chk("cfg_o", 18'h00211, cfg_o);
      chk("par_check_en_o", 18'(1), 18'(par_check_en_o));
      wr(SEL5, 1'b1, 1'b0);
      wr(SEL5, 1'b0, 1'b1);
      chk("cfg_o", 18'h00000, cfg_o);
      $display("end of status test");
   endtask
   task t_power;
      max_power_save_i = 1'b1;
      step(3);
      wr(SEL5 | 22'h01000, 1'b0, 1'b0);
      chk("cfg_o", 18'h00000, cfg_o);
      max_power_save_i = 1'b0;
      step(3);
      wr(SEL5 | 22'h01000, 1'b0, 1'b1);
      chk("cfg_o", 18'h01000, cfg_o);
      reset_n_i = 1'b0;
      step(5);
      reset_n_i = 1'b1;
      step(3);
      chk("cfg_o", 18'h00000, cfg_o);
      $display("end of power test");
   endtask
   // ---------------------------------------
   // main sequence and watchdog
   // ---------------------------------------
   initial begin
      step(5);
      rst_i = 1'b0;
      step(2);
      t_fields();
      t_pins();
      t_status();
      t_power();
      finish_test();
   end
   initial begin
      #300000;
      n_errors++;
      $display("Error watchdog expected end got timeout");
      finish_test();
   end
endmodule // dram_mode5_config_tb
